// file: rtl/smc_cfg.svh
// Constants for the switch memory command port: offsets, fields, commands, timing.
// Assumes inclusion by bare name from the top module, the checker and the bench.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// Register offsets on the plain register port
`define SMC_OFS_DATA 3'h0
`define SMC_OFS_ADDR 3'h1
`define SMC_OFS_CMD 3'h2
`define SMC_OFS_STATUS 3'h3
`define SMC_OFS_SUBPOS 3'h4
`define SMC_OFS_MODE 3'h5
// Field positions
`define SMC_STATUS_BUSY_BIT 0
`define SMC_MODE_STYLE_BIT 0
`define SMC_ADDR_DIR_BIT 7
// Reset values
`define SMC_DATA_RST 8'h00
`define SMC_ADDR_RST 8'h00
`define SMC_CMD_RST 8'h00
`define SMC_SUBPOS_RST 8'h00
`define SMC_MODE_RST 8'h00
// Command codes
`define SMC_CMD_IDLE_8 8'h08
`define SMC_CMD_IDLE_74 8'h18
`define SMC_CMD_IDLE_30 8'h10
`define SMC_CMD_IDLE_76 8'h38
`define SMC_CMD_IDLE_54 8'h30
`define SMC_CMD_IDLE_32 8'h28
`define SMC_CMD_IDLE_10 8'h20
`define SMC_CMD_DM_READ 8'h88
`define SMC_CMD_TS_WRITE 8'h60
`define SMC_CMD_TS_ALL 8'h68
`define SMC_CMD_TS_READ 8'hE0
`define SMC_CMD_CMD_WRITE 8'h48
`define SMC_CMD_CMD_READ 8'hC8
`define SMC_NIB_CM_WRITE 4'h7
`define SMC_NIB_CM_READ 4'hF
// Timing: the write-all tristate command runs for this many reference cycles
`define SMC_TS_ALL_CYCLES 1035
`endif

// file: rtl/smc_pkg.sv
// Types shared by the switch memory command port.
// Assumes smc_cfg.svh holds the numeric constants.
package smc_pkg;
    typedef enum logic [1:0] {
        SMC_IDLE,
        SMC_EXEC,
        SMC_FILL
    } smc_state_t;
    typedef enum logic [1:0] {
        SMC_DRV_OFF,
        SMC_DRV_LOW,
        SMC_DRV_HIGH
    } smc_drive_t;
endpackage

// file: rtl/smc_switch_memory_command_port.sv
// Indirect memory-command port: data, address and command registers reach
// the control memory and data memory; downstream port output driver logic.
// Assumes a single 20 MHz clock that also serves as reference clock and a
// synchronous active-low reset; the switching datapath lives outside.
// How it works
// - Command 0111xxxx writes data and code field
// - Code read returns code in low nibble
// - Code 0001 switches full byte, 64k
// - Codes 0011/0010 mark nibble subchannels, bits from subposition
// - Codes 0111..0100 mark bit-pair subchannels, bits from subposition
// - 0000 unassigned; 1000/1010/1011 preprocessed; 1001 processor
// - Driver state from code, subposition, style
// - Code 0000 keeps output inactive whole slot
// - Subchannels active only at selected position
// - Style bit selects three-state or open-drain
// - Drive levels per style and state
// - Idle writes select bit field by command
// - Command 88 reads data-memory entry
// - Command 60 writes one tristate field
// - Command 68 fills every tristate field
// - Command E0 reads one tristate field
// - Command 48 writes control data field only
// - Data-only commands keep code field
// - C8 reads data field, F0 reads code
// - Tristate bit drives subslot and indicator line
// - Write-all tristate takes 1035 cycles
`include "smc_cfg.svh"
module smc_switch_memory_command_port #(
    parameter int ENTRIES = 128,                       // Timeslot entries per direction
    parameter int TS_ALL_CYCLES = `SMC_TS_ALL_CYCLES   // Write-all duration in clocks
) (
    input wire logic i_clk,                 // 20 MHz clock
    input wire logic i_resetn,              // Synchronous reset, active low
    input wire logic [2:0] i_reg_addr,      // Register address
    input wire logic [7:0] i_reg_wdata,     // Register write data
    input wire logic i_reg_wr,              // Write strobe
    input wire logic i_reg_rd,              // Read strobe
    output logic [7:0] o_reg_rdata,         // Read data, cycle after strobe
    input wire logic [7:0] i_dm_rx_wdata,   // Received downstream byte
    input wire logic [6:0] i_dm_rx_addr,    // Downstream slot being received
    input wire logic i_dm_rx_we,            // Store received byte
    input wire logic [6:0] i_us_slot,       // Upstream slot being transmitted
    output logic [7:0] o_us_byte,           // Upstream byte being transmitted
    output logic [3:0] o_us_ts_field,       // Tristate field of that slot
    input wire logic [6:0] i_cfg_slot,      // Downstream port slot in progress
    input wire logic [2:0] i_cfg_bit,       // Bit position 7..0 within slot
    input wire logic i_cfg_bit_value,       // Logical value to send this bit
    output logic [7:0] o_cfg_data,          // Control data field of that slot
    output logic [3:0] o_cfg_code,          // Control code field of that slot
    output logic o_cfg_dout,                // Port output value
    output logic o_cfg_oe,                  // Port output enable
    output logic o_us_dout_oe,              // Upstream transmit enable
    output logic o_tsc_oe,                  // Tristate indicator line driven low
    output logic o_busy                     // Memory access busy
);
    localparam int AW = $clog2(ENTRIES);

    // Address map of the indirect port, as software sees it:
    //   data register     holds the value to store, and the result after a read
    //   address register  bit 7 picks the upstream half, the low bits the slot
    //   command register  starts a memory operation when written while idle
    //   status register   bit 0 reads back the busy flag
    //   subposition reg   one enable bit per bit position of a subchannel slot
    //   mode register     bit 0 picks open-drain (1) or three-state (0) outputs
    // Every memory operation takes one clock in the execute state. The
    // write-all tristate command then stays busy for the full sweep time, so
    // software written for the slow original sweep still sees the same wait.

    // Software-visible registers
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    logic [7:0] cmd_reg;
    logic [7:0] subpos_reg;
    logic [7:0] mode_reg;
    logic [7:0] rdata_reg;
    smc_pkg::smc_state_t state_reg;
    logic [10:0] fill_cnt_reg;

    // Memories: control data/code per downstream and upstream port slot,
    // data memory per direction, tristate field for upstream only
    logic [7:0] cm_data_mem [2*ENTRIES];
    logic [3:0] cm_code_mem [2*ENTRIES];
    logic [7:0] dm_up_mem [ENTRIES];
    logic [7:0] dm_dn_mem [ENTRIES];
    logic [3:0] ts_mem [ENTRIES];

    logic [AW:0] cm_idx;
    logic [AW-1:0] dm_idx;
    logic up_sel;
    logic [7:0] dm_up_next;
    logic [7:0] field_mask;
    logic data_wr;
    logic cmd_wr;

    // Address decode and strobe qualification.
    // The control memory is indexed by direction and slot, the data memory
    // only by slot because each direction has its own array.
    // A command write while busy is dropped rather than queued: a second
    // command would otherwise see half-updated data or address registers.
    assign up_sel = addr_reg[`SMC_ADDR_DIR_BIT];
    assign cm_idx = {up_sel, addr_reg[AW-1:0]};
    assign dm_idx = addr_reg[AW-1:0];
    assign data_wr = i_reg_wr && (i_reg_addr == `SMC_OFS_DATA);
    assign cmd_wr = i_reg_wr && (i_reg_addr == `SMC_OFS_CMD) && (state_reg == smc_pkg::SMC_IDLE);
    assign o_busy = (state_reg != smc_pkg::SMC_IDLE);

    // Idle-value field mask selected by the command.
    // Only the bits inside the mask are replaced, so several narrow idle
    // values can share one upstream byte without disturbing each other.
    // Any other command yields an empty mask and leaves the byte alone.
    always_comb begin
        unique case (cmd_reg)
            `SMC_CMD_IDLE_8: field_mask = 8'hFF;
            `SMC_CMD_IDLE_74: field_mask = 8'hF0;
            `SMC_CMD_IDLE_30: field_mask = 8'h0F;
            `SMC_CMD_IDLE_76: field_mask = 8'hC0;
            `SMC_CMD_IDLE_54: field_mask = 8'h30;
            `SMC_CMD_IDLE_32: field_mask = 8'h0C;
            `SMC_CMD_IDLE_10: field_mask = 8'h03;
            default: field_mask = 8'h00;
        endcase
        dm_up_next = (dm_up_mem[dm_idx] & ~field_mask) | (data_reg & field_mask);
    end

    // Configuration registers written by software
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            addr_reg <= `SMC_ADDR_RST;
            subpos_reg <= `SMC_SUBPOS_RST;
            mode_reg <= `SMC_MODE_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `SMC_OFS_ADDR)
                addr_reg <= i_reg_wdata;
            if (i_reg_addr == `SMC_OFS_SUBPOS)
                subpos_reg <= i_reg_wdata;
            if (i_reg_addr == `SMC_OFS_MODE)
                mode_reg <= i_reg_wdata;
        end
    end

    // Command acceptance and busy sequencing; commands while busy are dropped.
    // The fill state only counts out the remaining busy time: the tristate
    // locations themselves are all written in the execute cycle.
    // Busy lasts one execute cycle plus TS_ALL_CYCLES-1 fill cycles, TS_ALL_CYCLES total.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cmd_reg <= `SMC_CMD_RST;
            state_reg <= smc_pkg::SMC_IDLE;
            fill_cnt_reg <= 11'h000;
        end else begin
            unique case (state_reg)
                smc_pkg::SMC_IDLE: begin
                    if (cmd_wr) begin
                        cmd_reg <= i_reg_wdata;
                        state_reg <= smc_pkg::SMC_EXEC;
                    end
                end
                smc_pkg::SMC_EXEC: begin
                    if (cmd_reg == `SMC_CMD_TS_ALL) begin
                        fill_cnt_reg <= 11'(TS_ALL_CYCLES - 2);
                        state_reg <= smc_pkg::SMC_FILL;
                    end else begin
                        state_reg <= smc_pkg::SMC_IDLE;
                    end
                end
                smc_pkg::SMC_FILL: begin
                    fill_cnt_reg <= fill_cnt_reg - 11'h001;
                    if (fill_cnt_reg == 11'h000)
                        state_reg <= smc_pkg::SMC_IDLE;
                end
                default: state_reg <= smc_pkg::SMC_IDLE;
            endcase
        end
    end

    // Data register: software writes, command results load it.
    // Results land at the end of the execute cycle, so they are in place
    // by the time the busy flag reads back as clear. Software writes during
    // a command are ignored, keeping the operand stable while it is used.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            data_reg <= `SMC_DATA_RST;
        end else if (state_reg == smc_pkg::SMC_EXEC) begin
            if (cmd_reg[7:4] == `SMC_NIB_CM_READ)
                data_reg <= {4'h0, cm_code_mem[cm_idx]};
            else if (cmd_reg == `SMC_CMD_CMD_READ)
                data_reg <= cm_data_mem[cm_idx];
            else if (cmd_reg == `SMC_CMD_DM_READ)
                data_reg <= up_sel ? dm_up_mem[dm_idx] : dm_dn_mem[dm_idx];
            else if (cmd_reg == `SMC_CMD_TS_READ)
                data_reg <= {4'h0, ts_mem[dm_idx]};
        end else if (data_wr && state_reg == smc_pkg::SMC_IDLE) begin
            data_reg <= i_reg_wdata;
        end
    end

    // Control memory writes, only the addressed entry.
    // The data-only write leaves the code field untouched, so a slot keeps
    // its function while its pointer or idle value is changed.
    // Memories have no reset; software must program every slot it uses.
    always_ff @(posedge i_clk) begin
        if (state_reg == smc_pkg::SMC_EXEC) begin
            if (cmd_reg[7:4] == `SMC_NIB_CM_WRITE) begin
                cm_data_mem[cm_idx] <= data_reg;
                cm_code_mem[cm_idx] <= cmd_reg[3:0];
            end else if (cmd_reg == `SMC_CMD_CMD_WRITE) begin
                cm_data_mem[cm_idx] <= data_reg;
            end
        end
    end

    // Upstream data memory: idle writes from software, downstream from receiver.
    // The receive port owns the downstream array outright; software can
    // only read it, so there is no write conflict between the two sides.
    always_ff @(posedge i_clk) begin
        if (state_reg == smc_pkg::SMC_EXEC && field_mask != 8'h00)
            dm_up_mem[dm_idx] <= dm_up_next;
        if (i_dm_rx_we)
            dm_dn_mem[i_dm_rx_addr] <= i_dm_rx_wdata;
    end

    // Tristate field: one process per entry, so the write-all command
    // reaches every location in its execute cycle whatever the sweep time.
    // A single write touches only the entry whose index matches.
    for (genvar e = 0; e < ENTRIES; e++) begin : g_ts
        always_ff @(posedge i_clk) begin
            if (state_reg == smc_pkg::SMC_EXEC && cmd_reg == `SMC_CMD_TS_ALL)
                ts_mem[e] <= data_reg[3:0];
            else if (state_reg == smc_pkg::SMC_EXEC && cmd_reg == `SMC_CMD_TS_WRITE
                     && dm_idx == AW'(e))
                ts_mem[e] <= data_reg[3:0];
        end
    end

    // Register read port, data one cycle after the strobe; unmapped reads zero.
    // Outside a read slot the bus rests at zero, which keeps a wired-or
    // read mux upstream of this port free of stale values.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_reg <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                `SMC_OFS_DATA: rdata_reg <= data_reg;
                `SMC_OFS_ADDR: rdata_reg <= addr_reg;
                `SMC_OFS_CMD: rdata_reg <= cmd_reg;
                `SMC_OFS_STATUS: rdata_reg <= {7'h00, o_busy};
                `SMC_OFS_SUBPOS: rdata_reg <= subpos_reg;
                `SMC_OFS_MODE: rdata_reg <= mode_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign o_reg_rdata = rdata_reg;

    // Upstream transmit data and tristate lookup.
    // Both are registered, so the transmitter must present the slot index
    // one clock ahead of the slot it is about to send.
    logic [3:0] us_ts;
    logic us_sub_on;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_us_byte <= 8'h00;
            o_us_ts_field <= 4'h0;
        end else begin
            o_us_byte <= dm_up_mem[i_us_slot];
            o_us_ts_field <= ts_mem[i_us_slot];
        end
    end
    // One tristate bit per two-bit subslot: 1 drives and pulls indicator low
    assign us_ts = o_us_ts_field;
    assign us_sub_on = us_ts[i_cfg_bit[2:1]];
    assign o_us_dout_oe = us_sub_on;
    assign o_tsc_oe = us_sub_on;

    // Downstream slot fields for the switching datapath.
    // Only the downstream half of the control memory feeds the port drivers;
    // the upstream half is reached only through the command writes and reads of the register port.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_cfg_data <= 8'h00;
            o_cfg_code <= 4'h0;
        end else begin
            o_cfg_data <= cm_data_mem[{1'b0, i_cfg_slot[AW-1:0]}];
            o_cfg_code <= cm_code_mem[{1'b0, i_cfg_slot[AW-1:0]}];
        end
    end

    // Active window of a bit within the slot, decoded from the code.
    // Unassigned and unlisted codes keep the pin inactive all slot long.
    // For subchannel codes the position register alone picks the active
    // bits, since the code's bit field describes the other interface.
    // An open-drain one is never driven: the external pull-up makes it.
    logic bit_in_field;
    logic slot_active;
    smc_pkg::smc_drive_t drive;
    always_comb begin
        unique case (o_cfg_code)
            4'h1: bit_in_field = 1'b1;
            4'h3: bit_in_field = i_cfg_bit[2];
            4'h2: bit_in_field = !i_cfg_bit[2];
            4'h7: bit_in_field = (i_cfg_bit[2:1] == 2'h3);
            4'h6: bit_in_field = (i_cfg_bit[2:1] == 2'h2);
            4'h5: bit_in_field = (i_cfg_bit[2:1] == 2'h1);
            4'h4: bit_in_field = (i_cfg_bit[2:1] == 2'h0);
            4'h8, 4'h9, 4'hA, 4'hB: bit_in_field = 1'b1;
            default: bit_in_field = 1'b0;
        endcase
        // Subchannels take their active bits from the programmed position alone
        if (o_cfg_code >= 4'h2 && o_cfg_code <= 4'h7)
            slot_active = subpos_reg[i_cfg_bit];
        else
            slot_active = bit_in_field;
        if (!slot_active)
            drive = smc_pkg::SMC_DRV_OFF;
        else if (!i_cfg_bit_value)
            drive = smc_pkg::SMC_DRV_LOW;
        else if (mode_reg[`SMC_MODE_STYLE_BIT])
            drive = smc_pkg::SMC_DRV_OFF;
        else
            drive = smc_pkg::SMC_DRV_HIGH;
    end

    // Pin drive per output style.
    // The enable is high whenever the pin is driven; the value only
    // matters while the enable is high.
    assign o_cfg_oe = (drive != smc_pkg::SMC_DRV_OFF);
    assign o_cfg_dout = (drive == smc_pkg::SMC_DRV_HIGH);
endmodule

// file: verif/smc_port_chk.sv
// Checker for the switch memory command port: busy timing, read port, port drivers.
// Bound to the top module; sees only its ports.
`include "smc_cfg.svh"
module smc_port_chk #(
    parameter int TS_ALL_CYCLES = 1035 // Write-all duration
) (
    input wire logic i_clk, // Clock
    input wire logic i_resetn, // Reset, active low
    input wire logic [2:0] i_reg_addr, // Register address
    input wire logic [7:0] i_reg_wdata, // Write data
    input wire logic i_reg_wr, // Write strobe
    input wire logic i_reg_rd, // Read strobe
    input wire logic [7:0] o_reg_rdata, // Read data
    input wire logic [3:0] o_us_ts_field, // Tristate field
    input wire logic [2:0] i_cfg_bit, // Bit position
    input wire logic i_cfg_bit_value, // Bit value
    input wire logic [3:0] o_cfg_code, // Code field
    input wire logic o_cfg_dout, // Port value
    input wire logic o_cfg_oe, // Port enable
    input wire logic o_us_dout_oe, // Upstream enable
    input wire logic o_tsc_oe, // Indicator low
    input wire logic o_busy // Busy
);
    logic [15:0] busy_cnt;
    logic fill_r, style_r;
    logic [7:0] subpos_r;
    wire logic cmd_go = i_reg_wr && i_reg_addr == `SMC_OFS_CMD && !o_busy;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Busy length, kind of command, shadow of style and subchannel registers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            busy_cnt <= 16'h0000;
            fill_r <= 1'b0;
            style_r <= 1'b0;
            subpos_r <= 8'h00;
        end else begin
            busy_cnt <= o_busy ? busy_cnt + 16'h0001 : 16'h0000;
            if (cmd_go) fill_r <= i_reg_wdata == `SMC_CMD_TS_ALL;
            if (i_reg_wr && i_reg_addr == `SMC_OFS_MODE) style_r <= i_reg_wdata[0];
            if (i_reg_wr && i_reg_addr == `SMC_OFS_SUBPOS) subpos_r <= i_reg_wdata;
        end
    end
    // One cycle of busy, then idle
    sequence busy_pulse;
        o_busy ##1 !o_busy;
    endsequence
    AST_BUSY_PULSE: assert property (cmd_go && i_reg_wdata != `SMC_CMD_TS_ALL |=> busy_pulse)
        else $error("busy pulse wrong");
    AST_FILL_LEN: assert property ($fell(o_busy) |-> busy_cnt == (fill_r ? TS_ALL_CYCLES : 1))
        else $error("busy length wrong");
    AST_READ_QUIET: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_STATUS_BUSY: assert property (i_reg_rd && i_reg_addr == `SMC_OFS_STATUS |=> o_reg_rdata[0] == $past(o_busy))
        else $error("status busy bit wrong");
    AST_UNASSIGNED: assert property (o_cfg_code == 4'h0 |-> !o_cfg_oe)
        else $error("unassigned slot driven");
    AST_FULL_BYTE: assert property (o_cfg_code == 4'h1 |-> o_cfg_oe == (!style_r || !i_cfg_bit_value))
        else $error("full byte enable wrong");
    AST_SUB_SLOT: assert property (o_cfg_code inside {[4'h2:4'h7]} && !subpos_r[i_cfg_bit] |-> !o_cfg_oe)
        else $error("subchannel driven outside position");
    AST_OPEN_DRAIN: assert property (style_r && o_cfg_oe |-> !o_cfg_dout && !i_cfg_bit_value)
        else $error("open drain drove high");
    AST_THREE_STATE: assert property (!style_r && o_cfg_oe |-> o_cfg_dout == i_cfg_bit_value)
        else $error("three state value wrong");
    AST_TSC_LINE: assert property (o_tsc_oe |-> o_us_dout_oe && o_us_ts_field[i_cfg_bit[2:1]])
        else $error("indicator line wrong");
endmodule
bind smc_switch_memory_command_port smc_port_chk #(.TS_ALL_CYCLES(TS_ALL_CYCLES)) u_chk (.*);

// file: verif/smc_switch_memory_command_port_tb.sv
// Self-checking bench for the switch memory command port.
// Assumes the rtl files and the bound checker are compiled before it.
`include "smc_cfg.svh"
module smc_switch_memory_command_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TS = 20;
    localparam logic [7:0] SP = 8'h24;
    localparam logic [7:0] IC [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
    localparam logic [7:0] MK [7] = '{8'hFF, 8'hF0, 8'h0F, 8'hC0, 8'h30, 8'h0C, 8'h03};
    logic i_clk = 1'b0, i_resetn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic i_dm_rx_we = 1'b0, i_cfg_bit_value = 1'b0;
    logic [2:0] i_reg_addr = 3'h0, i_cfg_bit = 3'h0;
    logic [7:0] i_reg_wdata = 8'h00, i_dm_rx_wdata = 8'hC3, o_reg_rdata, o_us_byte, o_cfg_data;
    logic [6:0] i_dm_rx_addr = 7'h09, i_us_slot = 7'h03, i_cfg_slot = 7'h05;
    logic [3:0] o_us_ts_field, o_cfg_code;
    logic o_cfg_dout, o_cfg_oe, o_us_dout_oe, o_tsc_oe, o_busy;
    int err_total = 0;
    int cmp_count = 0;
    smc_switch_memory_command_port #(.TS_ALL_CYCLES(TS)) dut (.*);
    // 20 MHz clock
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask
    // Full command: data, address, command, poll busy, read data back
    task automatic cmd(input logic [7:0] a, d, c, output logic [7:0] r);
        logic [7:0] st;
        wr(`SMC_OFS_DATA, d);
        wr(`SMC_OFS_ADDR, a);
        wr(`SMC_OFS_CMD, c);
        st = 8'h01;
        for (int n = 0; n < 50 && st[0] !== 1'b0; n++) rd(`SMC_OFS_STATUS, st);
        if (st[0] !== 1'b0) begin
            chk("busy_clear", st, 8'h00);
            close_out();
        end
        rd(`SMC_OFS_DATA, r);
    endtask
    // Every control code: fields, then driver state per style, bit and value
    task automatic t_codes();
        logic [7:0] r;
        logic oe;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], r);
            chk("reg_reset", r, 8'h00);
        end
        wr(`SMC_OFS_SUBPOS, SP);
        for (int c = 0; c < 16; c++) begin
            cmd(8'h05, 8'hA0 | c[7:0], 8'h70 | c[7:0], r);
            cmd(8'h05, 8'h00, 8'hF0, r);
            chk("code_read", {4'h0, r[3:0]}, c[7:0]);
            chk("code_field", {4'h0, o_cfg_code}, c[7:0]);
            cmd(8'h05, 8'h00, `SMC_CMD_CMD_READ, r);
            chk("cm_data", r, 8'hA0 | c[7:0]);
            for (int k = 0; k < 32; k++) begin
                if (k % 16 == 0) wr(`SMC_OFS_MODE, {7'h00, k[4]});
                @(posedge i_clk);
                i_cfg_bit <= k[3:1];
                i_cfg_bit_value <= k[0];
                #1;
                oe = c != 0 && c < 12 && (c < 2 || c > 7 || SP[k[3:1]]) && (!k[4] || !k[0]);
                chk("oe", {7'h00, o_cfg_oe}, {7'h00, oe});
                if (oe) chk("dout", {7'h00, o_cfg_dout}, {7'h00, k[0] && !k[4]});
            end
        end
        cmd(8'h05, 8'h5A, `SMC_CMD_CMD_WRITE, r);
        cmd(8'h05, 8'h00, `SMC_CMD_CMD_READ, r);
        chk("cm_write", r, 8'h5A);
        cmd(8'h05, 8'h00, 8'hF0, r);
        chk("code_kept", {4'h0, r[3:0]}, 8'h0F);
    endtask
    // Idle-value field writes, data memory reads both ways
    task automatic t_idle();
        logic [7:0] r;
        cmd(8'h84, 8'h5A, `SMC_CMD_IDLE_8, r);
        for (int k = 0; k < 7; k++) begin
            cmd(8'h83, 8'h00, `SMC_CMD_IDLE_8, r);
            cmd(8'h83, 8'hFF, IC[k], r);
            cmd(8'h83, 8'h00, `SMC_CMD_DM_READ, r);
            chk("idle_read", r, MK[k]);
            chk("us_byte", o_us_byte, MK[k]);
        end
        cmd(8'h84, 8'h00, `SMC_CMD_DM_READ, r);
        chk("idle_other", r, 8'h5A);
        @(posedge i_clk);
        i_dm_rx_we <= 1'b1;
        @(posedge i_clk);
        i_dm_rx_we <= 1'b0;
        cmd(8'h09, 8'h00, `SMC_CMD_DM_READ, r);
        chk("rx_read", r, 8'hC3);
    endtask
    // Tristate fill timing, single write and read, indicator line
    task automatic t_tri();
        logic [7:0] r;
        int n;
        wr(`SMC_OFS_DATA, 8'hF9);
        wr(`SMC_OFS_CMD, `SMC_CMD_TS_ALL);
        #1;
        for (n = 0; n < 100 && o_busy === 1'b1; n++) @(posedge i_clk) #1;
        chk("fill_cycles", n[7:0], TS[7:0]);
        cmd(8'hFF, 8'h00, `SMC_CMD_TS_READ, r);
        chk("ts_all", {4'h0, r[3:0]}, 8'h09);
        cmd(8'h83, 8'h06, `SMC_CMD_TS_WRITE, r);
        cmd(8'h84, 8'h00, `SMC_CMD_TS_READ, r);
        chk("ts_other", {4'h0, r[3:0]}, 8'h09);
        cmd(8'h83, 8'h00, `SMC_CMD_TS_READ, r);
        chk("ts_one", {4'h0, r[3:0]}, 8'h06);
        chk("ts_field", {4'h0, o_us_ts_field}, 8'h06);
        for (int b = 0; b < 8; b++) begin
            @(posedge i_clk);
            i_cfg_bit <= b[2:0];
            #1;
            chk("tsc", {7'h00, o_tsc_oe}, {7'h00, b[2:1] inside {2'h1, 2'h2}});
        end
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_codes();
        t_idle();
        t_tri();
        close_out();
    end
endmodule
